// ==== rtl/sfd_pkg.sv ====
// shared constants for the spi fifo, dma and interrupt control block
package sfd_pkg;

    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [31:0] INT_CLEAR_IDX = 32'h5000_1306;
    localparam logic [31:0] SEC_CTRL_IDX  = 32'h5000_1308;
    localparam logic [31:0] IRQ_STAT_IDX  = 32'h5000_130a;
    localparam logic [31:0] IRQ_MASK_IDX  = 32'h5000_130b;

    localparam int ADDR_W = 12;

    // ------------------------------------------------------------
    // secondary control register layout and reset
    // ------------------------------------------------------------
    localparam int          LEAD_BIT_POS  = 4;
    localparam int          BUSY_POS      = 3;
    localparam int          PRIO_POS      = 2;
    localparam int          FIFO_MODE_LSB = 0;
    localparam int          REG_W         = 16;
    localparam logic [15:0] SEC_CTRL_RST  = 16'h0003;

    // ------------------------------------------------------------
    // fifo usage modes and word sizes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SFD_FIFO_BIDIR   = 2'h0,
        SFD_FIFO_RD_ONLY = 2'h1,
        SFD_FIFO_WR_ONLY = 2'h2,
        SFD_FIFO_NONE    = 2'h3
    } sfd_fifo_mode_t;

    localparam logic [1:0] WORD_9BIT = 2'h3;

    // ------------------------------------------------------------
    // interrupt status / mask layout
    // ------------------------------------------------------------
    localparam int         IRQ_DONE_BIT = 0;
    localparam int         IRQ_SUSP_BIT = 1;
    localparam int         IRQ_W        = 2;
    localparam logic [1:0] IRQ_RST      = 2'h0;

    // dma directions
    localparam int DMA_TX = 0;
    localparam int DMA_RX = 1;

    // byte address of a register index, cut to the decoded width
    function automatic logic [11:0] sfd_addr_of(input logic [31:0] idx);
        sfd_addr_of = {idx[9:0], 2'h0};
    endfunction : sfd_addr_of

endpackage : sfd_pkg

// ==== rtl/sfd_dma_req.sv ====
// one dma request line with low or high priority release
`timescale 1ns/100ps
module sfd_dma_req (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // control
    input  wire logic high_prio,
    input  wire logic want,
    // dma handshake
    input  wire logic ack,
    output logic      req
);

    logic armed;

    // low priority drops on ack and re-arms once ack falls; high priority
    // keeps the bus until the fifo can take or give no more
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req   <= 1'b0;
            armed <= 1'b1;
        end else if (high_prio) begin
            req   <= want;
            armed <= 1'b1;
        end else if (req && ack) begin
            req   <= 1'b0;
            armed <= 1'b0;
        end else begin
            armed <= armed | ~ack;
            req   <= want & (armed | ~ack) & ~ack;
        end
    end

    chk_low_prio_release : assert property (@(posedge hclk) disable iff (!hresetn)
        (!high_prio && req && ack) |=> !req)
        else $error("low priority request not dropped after ack");

    chk_high_prio_hold : assert property (@(posedge hclk) disable iff (!hresetn)
        (high_prio && want) |=> req)
        else $error("high priority request not held while fifo has room");

endmodule : sfd_dma_req

// ==== rtl/sfd_ctrl.sv ====
// spi interrupt clear, secondary control, busy, dma request and irq logic
//
// Contract
// - any write to the clear register clears the transfer flag unless a transfer sets it in the same cycle; reads give zero.
// - in nine-bit mode the first bit sent is the leading-bit field.
// - busy reads one during transfer, zero with no tx data or rx-full suspend.
// - priority clear drops each dma request on its acknowledge.
// - priority set holds dma requests until fifos are full or empty.
// - fifo mode zero uses both transmit and receive fifos.
// - fifo mode one uses receive fifo; transmit single depth, no flow control.
// - fifo mode two uses transmit fifo; receive single depth, no flow control.
// - fifo mode three disables both fifos and is the reset value.
// - transfer flag sets when data moved and stays until software clears it.
// - word size code three means nine-bit words, master mode only.
`timescale 1ns/100ps
module sfd_ctrl (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // main control and shift engine
    input  wire logic [1:0]  word_size,
    input  wire logic        slave_mode,
    input  wire logic        xfer_done,
    input  wire logic        tx_data_avail,
    input  wire logic        tx_fifo_full,
    input  wire logic        rx_fifo_full,
    input  wire logic        rx_fifo_empty,
    output logic             xfer_int_flag,
    output logic             nine_bit_mode,
    output logic             leading_bit_out,
    output logic             tx_fifo_en,
    output logic             rx_fifo_en,
    // dma controller
    input  wire logic        dma_tx_ack,
    input  wire logic        dma_rx_ack,
    output logic             dma_tx_req,
    output logic             dma_rx_req,
    // interrupt
    output logic             irq
);

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    localparam logic [11:0] A_CLEAR = sfd_pkg::sfd_addr_of(sfd_pkg::INT_CLEAR_IDX);
    localparam logic [11:0] A_SEC   = sfd_pkg::sfd_addr_of(sfd_pkg::SEC_CTRL_IDX);
    localparam logic [11:0] A_STAT  = sfd_pkg::sfd_addr_of(sfd_pkg::IRQ_STAT_IDX);
    localparam logic [11:0] A_MASK  = sfd_pkg::sfd_addr_of(sfd_pkg::IRQ_MASK_IDX);

    logic        acc;
    logic        wr_pend;
    logic        rd_pend;
    logic [11:0] dph_addr;
    logic        wr_clear;
    logic        wr_sec;
    logic        wr_stat;
    logic        wr_mask;

    logic        lead_bit;
    logic        prio;
    logic [1:0]  fifo_mode;
    logic        busy;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [1:0]  irq_evt;
    logic        susp_q;
    logic        rx_suspend;
    logic [1:0]  dma_want;
    logic [1:0]  dma_ack;
    logic [1:0]  dma_req;

    assign acc = hsel & htrans[1] & hready;

    // address phase capture; reads get one wait state so that a read right
    // after a write sees the written value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            dph_addr  <= 12'h000;
            hreadyout <= 1'b1;
        end else begin
            wr_pend  <= acc & hwrite;
            rd_pend  <= acc & ~hwrite;
            if (acc) begin
                dph_addr <= haddr;
            end
            hreadyout <= ~(acc & ~hwrite);
        end
    end

    // data phase write strobes; hsize is ignored, only whole words are used
    assign wr_clear = wr_pend & (dph_addr == A_CLEAR);
    assign wr_sec   = wr_pend & (dph_addr == A_SEC);
    assign wr_stat  = wr_pend & (dph_addr == A_STAT);
    assign wr_mask  = wr_pend & (dph_addr == A_MASK);

    // read mux, loaded in the wait state; the clear register and unmapped
    // addresses read zero, response is always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hresp  <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (rd_pend) begin
                unique case (dph_addr)
                    A_CLEAR: hrdata <= 32'h0000_0000;
                    A_SEC:   hrdata <= {27'h000_0000, lead_bit, busy, prio, fifo_mode};
                    A_STAT:  hrdata <= {30'h0000_0000, irq_stat};
                    A_MASK:  hrdata <= {30'h0000_0000, irq_mask};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // secondary control register
    // ------------------------------------------------------------
    // reserved bits are simply not stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lead_bit  <= sfd_pkg::SEC_CTRL_RST[sfd_pkg::LEAD_BIT_POS];
            prio      <= sfd_pkg::SEC_CTRL_RST[sfd_pkg::PRIO_POS];
            fifo_mode <= sfd_pkg::SEC_CTRL_RST[sfd_pkg::FIFO_MODE_LSB +: 2];
        end else if (wr_sec) begin
            lead_bit  <= hwdata[sfd_pkg::LEAD_BIT_POS];
            prio      <= hwdata[sfd_pkg::PRIO_POS];
            fifo_mode <= hwdata[sfd_pkg::FIFO_MODE_LSB +: 2];
        end
    end

    // fifo enables per mode; a disabled side falls back to single depth
    // without flow control in the data path outside
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_fifo_en <= 1'b0;
            rx_fifo_en <= 1'b0;
        end else begin
            unique case (sfd_pkg::sfd_fifo_mode_t'(fifo_mode))
                sfd_pkg::SFD_FIFO_BIDIR: begin
                    tx_fifo_en <= 1'b1;
                    rx_fifo_en <= 1'b1;
                end
                sfd_pkg::SFD_FIFO_RD_ONLY: begin
                    tx_fifo_en <= 1'b0;
                    rx_fifo_en <= 1'b1;
                end
                sfd_pkg::SFD_FIFO_WR_ONLY: begin
                    tx_fifo_en <= 1'b1;
                    rx_fifo_en <= 1'b0;
                end
                sfd_pkg::SFD_FIFO_NONE: begin
                    tx_fifo_en <= 1'b0;
                    rx_fifo_en <= 1'b0;
                end
            endcase
        end
    end

    // nine-bit words only in master mode; the leading bit value goes to the
    // shifter, which sends it first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nine_bit_mode   <= 1'b0;
            leading_bit_out <= 1'b0;
        end else begin
            nine_bit_mode   <= (word_size == sfd_pkg::WORD_9BIT) & ~slave_mode;
            leading_bit_out <= lead_bit;
        end
    end

    // ------------------------------------------------------------
    // busy and transfer flag
    // ------------------------------------------------------------
    // suspension only exists where the receive side has flow control
    assign rx_suspend = rx_fifo_full & rx_fifo_en;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy <= 1'b0;
        end else begin
            busy <= tx_data_avail & ~rx_suspend;
        end
    end

    // set wins over a clear write in the same cycle so no transfer is lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xfer_int_flag <= 1'b0;
        end else if (xfer_done) begin
            xfer_int_flag <= 1'b1;
        end else if (wr_clear) begin
            xfer_int_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // dma requests
    // ------------------------------------------------------------
    assign dma_want[sfd_pkg::DMA_TX] = tx_fifo_en & ~tx_fifo_full;
    assign dma_want[sfd_pkg::DMA_RX] = rx_fifo_en & ~rx_fifo_empty;
    assign dma_ack                   = {dma_rx_ack, dma_tx_ack};

    for (genvar d = 0; d < 2; d++) begin : g_dma
        sfd_dma_req u_req (
            .hclk      (hclk),
            .hresetn   (hresetn),
            .high_prio (prio),
            .want      (dma_want[d]),
            .ack       (dma_ack[d]),
            .req       (dma_req[d])
        );
    end

    assign dma_tx_req = dma_req[sfd_pkg::DMA_TX];
    assign dma_rx_req = dma_req[sfd_pkg::DMA_RX];

    // ------------------------------------------------------------
    // interrupt status, mask and output
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            susp_q <= 1'b0;
        end else begin
            susp_q <= rx_suspend;
        end
    end

    assign irq_evt[sfd_pkg::IRQ_DONE_BIT] = xfer_done;
    assign irq_evt[sfd_pkg::IRQ_SUSP_BIT] = rx_suspend & ~susp_q;

    // write one to clear; a new event beats the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= sfd_pkg::IRQ_RST;
        end else begin
            irq_stat <= irq_evt | (irq_stat & ~(wr_stat ? hwdata[1:0] : 2'h0));
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= sfd_pkg::IRQ_RST;
        end else if (wr_mask) begin
            irq_mask <= hwdata[1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_clear_reads_zero : assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_pend && dph_addr == A_CLEAR) |=> (hrdata == 32'h0000_0000))
        else $error("clear register read returned nonzero");

    chk_clear_flag : assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_clear && !xfer_done) |=> !xfer_int_flag)
        else $error("transfer flag not cleared by write");

    chk_flag_sticky : assert property (@(posedge hclk) disable iff (!hresetn)
        (xfer_done || (xfer_int_flag && !wr_clear)) |=> xfer_int_flag)
        else $error("transfer flag lost before clear");

    chk_lead_bit : assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> (leading_bit_out == $past(lead_bit)))
        else $error("leading bit output does not follow field");

    chk_busy_state : assert property (@(posedge hclk) disable iff (!hresetn)
        (!tx_data_avail || rx_suspend) |=> !busy)
        else $error("busy set with no data or while suspended");

    chk_nine_bit : assert property (@(posedge hclk) disable iff (!hresetn)
        slave_mode |=> !nine_bit_mode)
        else $error("nine-bit mode in slave mode");

    chk_mode_bidir : assert property (@(posedge hclk) disable iff (!hresetn)
        (fifo_mode == 2'h0) |=> (tx_fifo_en && rx_fifo_en))
        else $error("bidirectional mode lacks a fifo");

    chk_mode_rd : assert property (@(posedge hclk) disable iff (!hresetn)
        (fifo_mode == 2'h1) |=> (!tx_fifo_en && rx_fifo_en))
        else $error("read only mode fifo enables wrong");

    chk_mode_wr : assert property (@(posedge hclk) disable iff (!hresetn)
        (fifo_mode == 2'h2) |=> (tx_fifo_en && !rx_fifo_en))
        else $error("write only mode fifo enables wrong");

    chk_mode_none : assert property (@(posedge hclk) disable iff (!hresetn)
        (fifo_mode == 2'h3) |=> (!tx_fifo_en && !rx_fifo_en))
        else $error("no-fifo mode has a fifo enabled");

    chk_reserved_zero : assert property (@(posedge hclk) disable iff (!hresetn)
        (rd_pend && dph_addr == A_SEC) |=> (hrdata[31:5] == 27'h000_0000))
        else $error("reserved bits read nonzero");

endmodule : sfd_ctrl

// ==== bench/sfd_dma_partner.sv ====
// dma controller model answering the block's two request lines
`timescale 1ns/100ps
module sfd_dma_partner (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // answer delay in cycles, zero for a prompt controller
    input  wire logic [3:0] ack_delay,
    // dma handshake
    input  wire logic       dma_tx_req,
    input  wire logic       dma_rx_req,
    output logic            dma_tx_ack,
    output logic            dma_rx_ack
);
    logic [3:0] wait_cnt [2];
    logic [1:0] req_v;
    logic [1:0] ack_v;

    assign req_v      = {dma_rx_req, dma_tx_req};
    assign dma_tx_ack = ack_v[0];
    assign dma_rx_ack = ack_v[1];

    // one-cycle acknowledge per grant; a held request is granted again, as a real bus arbiter would
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ack_v       <= 2'h0;
            wait_cnt[0] <= 4'h0;
            wait_cnt[1] <= 4'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (ack_v[i]) begin
                    ack_v[i] <= 1'b0;
                end else if (req_v[i] && wait_cnt[i] >= ack_delay) begin
                    ack_v[i]    <= 1'b1;
                    wait_cnt[i] <= 4'h0;
                end else if (req_v[i]) begin
                    wait_cnt[i] <= wait_cnt[i] + 4'h1;
                end else begin
                    wait_cnt[i] <= 4'h0;
                end
            end
        end
    end
endmodule : sfd_dma_partner

// ==== bench/tb_top.sv ====
// self-checking bench for the spi fifo, dma and interrupt control block
`timescale 1ns/100ps
module tb_top;
    localparam logic [11:0] A_CLR = 12'hc18, A_CTRL = 12'hc20, A_STAT = 12'hc28, A_MASK = 12'hc2c;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0, word_size = 2'h0;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic slave_mode = 1'b0, xfer_done = 1'b0, tx_data_avail = 1'b0, tx_fifo_full = 1'b1;
    logic rx_fifo_full = 1'b0, rx_fifo_empty = 1'b1, hreadyout, hresp, rdy_s, xfer_int_flag, nine_bit_mode;
    logic leading_bit_out, tx_fifo_en, rx_fifo_en, dma_tx_ack, dma_rx_ack, dma_tx_req, dma_rx_req, irq;
    logic [3:0] ack_delay = 4'h0;
    logic [31:0] hrd_s;
    logic        rsp_s;
    int mismatches = 0, comparisons = 0, cycles = 0;

    always #2.5 hclk = ~hclk;
    // sample at each falling edge, half a cycle before the rising edge, so the bus tasks never race the slave's updates
    always @(negedge hclk) begin
        rdy_s = hreadyout;
        hrd_s = hrdata;
        rsp_s = hresp;
    end

    sfd_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .word_size(word_size), .slave_mode(slave_mode),
        .xfer_done(xfer_done), .tx_data_avail(tx_data_avail), .tx_fifo_full(tx_fifo_full),
        .rx_fifo_full(rx_fifo_full), .rx_fifo_empty(rx_fifo_empty), .xfer_int_flag(xfer_int_flag),
        .nine_bit_mode(nine_bit_mode), .leading_bit_out(leading_bit_out), .tx_fifo_en(tx_fifo_en),
        .rx_fifo_en(rx_fifo_en), .dma_tx_ack(dma_tx_ack), .dma_rx_ack(dma_rx_ack),
        .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req), .irq(irq));

    sfd_dma_partner dma (.hclk(hclk), .hresetn(hresetn), .ack_delay(ack_delay), .dma_tx_req(dma_tx_req),
        .dma_rx_req(dma_rx_req), .dma_tx_ack(dma_tx_ack), .dma_rx_ack(dma_rx_ack));

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
        // return on a rising edge so whatever the caller drives next is launched there, not mid-cycle
        @(posedge hclk);
    endtask : check

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report

    // a hang ends in the same report
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // ahb-lite single word transfers
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge hclk); while (rdy_s !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (rdy_s !== 1'b1);
        q = hrd_s;
    endtask : bus

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, exp);
        check({31'h0, rsp_s}, 32'h0);
    endtask : rd_chk

    task automatic settle();
        repeat (2) @(posedge hclk);
        @(negedge hclk);
    endtask : settle

    // wait for a granted request on one direction, then look one edge later
    task automatic grant_then(input int dir, input logic exp_req);
        int n;
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (!((dir == 0) ? (dma_tx_req && dma_tx_ack) : (dma_rx_req && dma_rx_ack)) && n < 60);
        @(negedge hclk);
        check({31'h0, (dir == 0) ? dma_tx_req : dma_rx_req}, {31'h0, exp_req});
        // a request that never rose must not pass as a dropped one
        check({31'h0, n < 60}, 32'h1);
    endtask : grant_then

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk(A_CTRL, 32'h3);
        rd_chk(A_CLR, 32'h0);
        rd_chk(12'h004, 32'h0);
        check({30'h0, tx_fifo_en, rx_fifo_en}, 32'h0);
        $display("test reset_values done");

        wr(A_CTRL, 32'hffff_ffff);
        rd_chk(A_CTRL, 32'h17);
        for (int m = 0; m < 4; m++) begin
            wr(A_CTRL, m);
            settle();
            check({30'h0, tx_fifo_en, rx_fifo_en}, {30'h0, ~m[0], ~m[1]});
        end
        $display("test fifo_modes done");

        word_size <= 2'h3;
        wr(A_CTRL, 32'h13);
        settle();
        check({30'h0, nine_bit_mode, leading_bit_out}, 32'h3);
        slave_mode <= 1'b1;
        wr(A_CTRL, 32'h03);
        settle();
        check({30'h0, nine_bit_mode, leading_bit_out}, 32'h0);
        slave_mode <= 1'b0;
        $display("test nine_bit done");

        wr(A_CTRL, 32'h0);
        tx_data_avail <= 1'b1;
        settle();
        rd_chk(A_CTRL, 32'h8);
        rx_fifo_full <= 1'b1;
        settle();
        rd_chk(A_CTRL, 32'h0);
        tx_data_avail <= 1'b0;
        rx_fifo_full  <= 1'b0;
        rd_chk(A_STAT, 32'h2);
        wr(A_STAT, 32'h3);
        $display("test busy done");

        wr(A_MASK, 32'h1);
        @(posedge hclk);
        xfer_done <= 1'b1;
        @(posedge hclk);
        xfer_done <= 1'b0;
        repeat (5) @(posedge hclk);
        @(negedge hclk);
        check({30'h0, xfer_int_flag, irq}, 32'h3);
        wr(A_CLR, 32'h0);
        settle();
        check({31'h0, xfer_int_flag}, 32'h0);
        rd_chk(A_STAT, 32'h1);
        wr(A_MASK, 32'h0);
        settle();
        check({31'h0, irq}, 32'h0);
        wr(A_STAT, 32'h1);
        rd_chk(A_STAT, 32'h0);
        $display("test flag_and_irq done");

        ack_delay    <= 4'h3;
        tx_fifo_full <= 1'b0;
        grant_then(0, 1'b0);
        rx_fifo_empty <= 1'b0;
        grant_then(1, 1'b0);
        ack_delay <= 4'h0;
        wr(A_CTRL, 32'h4);
        grant_then(0, 1'b1);
        grant_then(1, 1'b1);
        tx_fifo_full  <= 1'b1;
        rx_fifo_empty <= 1'b1;
        settle();
        check({30'h0, dma_tx_req, dma_rx_req}, 32'h0);
        $display("test dma done");
        final_report();
    end
endmodule : tb_top
